// File: hdl/obcl_top.sv
// option byte loader: supply reset, byte fetch, decode, register slave
// Functional notes
// R1: four option bytes at C0..C3, three user bytes and one debug byte.
// R2: bytes are read after every reset release before the core runs.
// R3: watchdog byte bit 4 starts the watchdog counter after reset.
// R4: period code picks overflow of 2^n-1 slow clocks, n from table.
// R5: same code picks interval time of three quarters of 2^n.
// R6: watchdog byte bit 0 keeps counting in halt and stop.
// R7: programmer must not pair stopped counter with standby counting.
// R8: programmer writes every unassigned option bit as one.
// R9: interval interrupt raised each interval unless software mask is set.
// R10: supply byte bit 4 makes shared pin a reset input, else port.
// R11: supply byte bits 3:2 select rise and fall detection thresholds.
// R12: oscillator byte codes 1 to 5 select 20 down to 1.25 MHz.
// R13: internal reset held from power-up until supply above rise level.
// R14: internal reset released once comparator reports rise threshold.
// R15: internal reset reasserted when supply falls below fall threshold.
// R16: reset processing also covers oscillator settling before core starts.
// R17: programmer always writes every option byte.
// R18: software should wait out supply wobble before port setup.
// R19: debug byte enables or disables on-chip debug after reset.
// R20: supply reset sets bit 0 of the reset cause register.
// R21: decoded settings latched on load and held until next reload.
`timescale 1ns/100ps
`include "obcl_map.svh"
module obcl_top import obcl_pkg::*; #(
  parameter int STAB_CYCLES = `OBCL_STAB_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_supply_above_rise,
  input wire logic i_supply_below_fall,
  input wire logic i_nvm_ack,
  input wire obcl_byte_t i_nvm_rdata,
  output logic o_nvm_req,
  output logic [19:0] o_nvm_addr,
  input wire logic i_wdt_interval_tick,
  output logic o_wdt_interval_irq,
  output logic o_int_rst_n,
  output logic o_cpu_run,
  output logic o_cfg_loaded,
  output logic o_wdt_run_enable,
  output logic o_wdt_standby_run,
  output logic [15:0] o_wdt_overflow_cnt,
  output logic [15:0] o_wdt_interval_cnt,
  output logic o_reset_pin_select,
  output logic [1:0] o_detect_level_sel,
  output logic [2:0] o_osc_freq_sel,
  output logic o_osc_freq_bad,
  output logic o_debug_enable
);
  // exponent n of the watchdog period for each code
  function automatic logic [4:0] wdt_exp(input logic [2:0] code);
    case (code)
      3'h0: wdt_exp = 5'h06;
      3'h1: wdt_exp = 5'h07;
      3'h2: wdt_exp = 5'h08;
      3'h3: wdt_exp = 5'h09;
      3'h4: wdt_exp = 5'h0B;
      3'h5: wdt_exp = 5'h0D;
      3'h6: wdt_exp = 5'h0E;
      default: wdt_exp = 5'h10;
    endcase
  endfunction
  function automatic logic [16:0] pow2(input logic [2:0] code);
    pow2 = 17'h00001 << wdt_exp(code);
  endfunction

  logic rd_valid, rd_done, supply_level_reset_event;
  logic [1:0] rd_idx;
  obcl_byte_t rd_data;
  obcl_byte_t opt_reg [4];
  obcl_byte_t opt_next [4];
  logic loaded_next, run_next;
  logic stby_next, wdt_next, pin_next, dbg_next, bad_next;
  logic [15:0] ovf_next, ivl_next;
  logic [1:0] lvl_next;
  logic [2:0] frq_next;
  logic [2:0] sel_code;
  logic [16:0] period;

  obcl_supply_reset #(
    .STAB_CYCLES(STAB_CYCLES)
  ) u_supply (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_above_rise(i_supply_above_rise),
    .i_below_fall(i_supply_below_fall),
    .o_int_rst_n(o_int_rst_n),
    .o_reset_event(supply_level_reset_event)
  );

  // fetch restarts whenever the internal reset drops again
  obcl_nvm_reader u_reader (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_enable(o_int_rst_n),
    .i_nvm_ack(i_nvm_ack),
    .i_nvm_rdata(i_nvm_rdata),
    .o_nvm_req(o_nvm_req),
    .o_nvm_addr(o_nvm_addr),
    .o_cap_valid(rd_valid),
    .o_cap_idx(rd_idx),
    .o_cap_data(rd_data),
    .o_done(rd_done)
  );

  // capture and decode group
  always_comb begin
    opt_next = opt_reg;
    loaded_next = o_cfg_loaded;
    wdt_next = o_wdt_run_enable;
    stby_next = o_wdt_standby_run;
    ovf_next = o_wdt_overflow_cnt;
    ivl_next = o_wdt_interval_cnt;
    pin_next = o_reset_pin_select;
    lvl_next = o_detect_level_sel;
    frq_next = o_osc_freq_sel;
    bad_next = o_osc_freq_bad;
    dbg_next = o_debug_enable;
    sel_code = opt_reg[0][`OBCL_WDT_SEL_HI:`OBCL_WDT_SEL_LO];
    period = pow2(sel_code);
    if (rd_valid) begin
      opt_next[rd_idx] = rd_data; // R1
    end
    // decode waits until the last byte has landed in the shadow
    if (!o_int_rst_n) begin
      loaded_next = 1'b0; // R21
    end else if (rd_done && !rd_valid && !o_cfg_loaded) begin // R2
      loaded_next = 1'b1;
      wdt_next = opt_reg[0][`OBCL_WDT_RUN_BIT]; // R3
      stby_next = opt_reg[0][`OBCL_WDT_STBY_BIT]; // R6
      ovf_next = 16'(period - 17'h00001); // R4
      ivl_next = 16'(period - (period >> 2)); // R5
      pin_next = opt_reg[1][`OBCL_PIN_SEL_BIT]; // R10
      lvl_next = opt_reg[1][`OBCL_LVL_HI:`OBCL_LVL_LO]; // R11
      frq_next = opt_reg[2][`OBCL_FRQ_HI:`OBCL_FRQ_LO]; // R12
      // prohibited codes are passed on but flagged
      bad_next = frq_next < `OBCL_FRQ_MIN || frq_next > `OBCL_FRQ_MAX;
      dbg_next = opt_reg[3][`OBCL_DBG_EN_BIT]; // R19
    end
    run_next = o_int_rst_n && loaded_next; // R2
  end

  // decoded settings keep their last load while the internal reset is active; load flag and core run clear
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < 4; i++) begin
        opt_reg[i] <= `OBCL_OPT_RST;
      end
      o_cfg_loaded <= 1'b0;
      o_cpu_run <= 1'b0;
      o_wdt_run_enable <= 1'b0;
      o_wdt_standby_run <= 1'b0;
      o_wdt_overflow_cnt <= 16'h0000;
      o_wdt_interval_cnt <= 16'h0000;
      o_reset_pin_select <= 1'b0;
      o_detect_level_sel <= `OBCL_LVL_RST;
      o_osc_freq_sel <= `OBCL_FRQ_MIN;
      o_osc_freq_bad <= 1'b0;
      o_debug_enable <= 1'b0;
    end else begin
      opt_reg <= opt_next;
      o_cfg_loaded <= loaded_next;
      o_cpu_run <= run_next;
      o_wdt_run_enable <= wdt_next;
      o_wdt_standby_run <= stby_next;
      o_wdt_overflow_cnt <= ovf_next;
      o_wdt_interval_cnt <= ivl_next;
      o_reset_pin_select <= pin_next;
      o_detect_level_sel <= lvl_next;
      o_osc_freq_sel <= frq_next;
      o_osc_freq_bad <= bad_next;
      o_debug_enable <= dbg_next;
    end
  end

  // bus slave, control, cause and interrupt group
  logic [9:0] widx;
  logic ack_next, irq_next, combo_err;
  logic [31:0] dat_next;
  obcl_byte_t ctrl_reg, ctrl_next, cause_reg, cause_next;
  always_comb begin
    widx = i_wb_adr[11:2];
    ack_next = i_wb_cyc && i_wb_stb && !o_wb_ack;
    dat_next = 32'h00000000;
    ctrl_next = ctrl_reg;
    cause_next = cause_reg;
    combo_err = !o_wdt_run_enable && o_wdt_standby_run; // R7
    if (ack_next && !i_wb_we) begin
      if (widx == `OBCL_OPT_WDT_IDX) begin
        dat_next[7:0] = opt_reg[0];
      end else if (widx == `OBCL_OPT_SUP_IDX) begin
        dat_next[7:0] = opt_reg[1];
      end else if (widx == `OBCL_OPT_OSC_IDX) begin
        dat_next[7:0] = opt_reg[2];
      end else if (widx == `OBCL_OPT_DBG_IDX) begin
        dat_next[7:0] = opt_reg[3];
      end else if (widx == `OBCL_CTRL_IDX) begin
        dat_next[7:0] = ctrl_reg;
      end else if (widx == `OBCL_STAT_IDX) begin
        dat_next[3:0] = {combo_err, o_osc_freq_bad, !o_int_rst_n,
                         o_cfg_loaded};
      end else if (widx == `OBCL_CAUSE_IDX) begin
        dat_next[7:0] = cause_reg;
        cause_next = 8'h00; // read clears
      end
    end
    // write lands on the edge where the master sees ack
    if (o_wb_ack && i_wb_we && i_wb_sel[0] && widx == `OBCL_CTRL_IDX) begin
      ctrl_next = {7'h00, i_wb_dat[`OBCL_CTRL_MASK_BIT]};
    end
    if (supply_level_reset_event) begin
      cause_next[`OBCL_CAUSE_SUPPLY_LEVEL_RESET_BIT] = 1'b1; // R20
    end
    irq_next = i_wdt_interval_tick && !ctrl_reg[`OBCL_CTRL_MASK_BIT]; // R9
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      ctrl_reg <= `OBCL_CTRL_RST;
      cause_reg <= `OBCL_CAUSE_RST;
      o_wdt_interval_irq <= 1'b0;
    end else begin
      o_wb_ack <= ack_next;
      o_wb_dat <= dat_next;
      ctrl_reg <= ctrl_next;
      cause_reg <= cause_next;
      o_wdt_interval_irq <= irq_next;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  a_run_after_load: assert property ( // R2
    $rose(o_cpu_run) |-> o_cfg_loaded && $past(rd_done) && o_int_rst_n)
    else $error("core started before option bytes loaded");
  a_wdt_run_bit: assert property ( // R3
    $rose(o_cfg_loaded) |-> o_wdt_run_enable == $past(opt_reg[0][4]))
    else $error("watchdog run bit not taken from option byte");
  a_overflow_code4: assert property ( // R4
    $rose(o_cfg_loaded) && $past(opt_reg[0][3:1]) == 3'h4
    |-> o_wdt_overflow_cnt == 16'h07FF)
    else $error("overflow count wrong for code 4");
  a_interval_code7: assert property ( // R5
    $rose(o_cfg_loaded) && $past(opt_reg[0][3:1]) == 3'h7
    |-> o_wdt_interval_cnt == 16'hC000)
    else $error("interval count wrong for code 7");
  a_irq_unmasked: assert property ( // R9
    i_wdt_interval_tick && !ctrl_reg[0] |=> o_wdt_interval_irq)
    else $error("interval interrupt lost while unmasked");
  a_irq_masked: assert property ( // R9
    ctrl_reg[0] |=> !o_wdt_interval_irq)
    else $error("interval interrupt passed while masked");
  a_freq_bad_flag: assert property ( // R12
    $rose(o_cfg_loaded) && $past(opt_reg[2][2:0]) == 3'h6
    |-> o_osc_freq_bad)
    else $error("prohibited frequency code not flagged");
  a_cause_set: assert property ( // R20
    supply_level_reset_event |=> cause_reg[0])
    else $error("supply reset cause bit not set");
  a_cfg_held: assert property ( // R21
    o_cfg_loaded && $past(o_cfg_loaded) |-> $stable(o_wdt_overflow_cnt)
    && $stable(o_detect_level_sel) && $stable(o_debug_enable))
    else $error("settings changed while loaded");
  a_standby_bit: assert property ( // R6
    $rose(o_cfg_loaded) |-> o_wdt_standby_run == $past(opt_reg[0][0]))
    else $error("standby run bit not taken from option byte");
  a_pin_select: assert property ( // R10
    $rose(o_cfg_loaded) |-> o_reset_pin_select == $past(opt_reg[1][4]))
    else $error("shared pin select not taken from option byte");
  a_detect_level: assert property ( // R11
    $rose(o_cfg_loaded) |-> o_detect_level_sel == $past(opt_reg[1][3:2]))
    else $error("detect level not taken from option byte");
  a_debug_bit: assert property ( // R19
    $rose(o_cfg_loaded) |-> o_debug_enable == $past(opt_reg[3][7]))
    else $error("debug enable not taken from option byte");
  a_run_in_reset: assert property ( // R2
    !o_int_rst_n |=> !o_cpu_run)
    else $error("core kept running under internal reset");
  a_nvm_addr_range: assert property ( // R1
    o_nvm_req |-> o_nvm_addr[19:2] == 18'h00030)
    else $error("fetch address outside the option area");

  c_load_done: cover property ($rose(o_cfg_loaded));
  c_irq_out: cover property (o_wdt_interval_irq);
  c_supply_level_reset_again: cover property (o_cpu_run ##[1:100] supply_level_reset_event);
  c_cause_read: cover property (o_wb_ack && cause_reg == 8'h00);
  c_bad_code: cover property ($rose(o_cfg_loaded) && o_osc_freq_bad);
endmodule

// File: hdl/obcl_map.svh
// register map, field positions, reset values and timing of the loader
`ifndef OBCL_MAP_SVH
`define OBCL_MAP_SVH
`define OBCL_OPT_WDT_IDX 10'h0C0
`define OBCL_OPT_SUP_IDX 10'h0C1
`define OBCL_OPT_OSC_IDX 10'h0C2
`define OBCL_OPT_DBG_IDX 10'h0C3
`define OBCL_CTRL_IDX 10'h0D0
`define OBCL_STAT_IDX 10'h0D1
`define OBCL_CAUSE_IDX 10'h0D2
`define OBCL_NVM_BASE 20'h000C0
`define OBCL_OPT_LAST 2'h3
`define OBCL_WDT_RUN_BIT 4
`define OBCL_WDT_SEL_HI 3
`define OBCL_WDT_SEL_LO 1
`define OBCL_WDT_STBY_BIT 0
`define OBCL_PIN_SEL_BIT 4
`define OBCL_LVL_HI 3
`define OBCL_LVL_LO 2
`define OBCL_FRQ_HI 2
`define OBCL_FRQ_LO 0
`define OBCL_FRQ_MIN 3'h1
`define OBCL_FRQ_MAX 3'h5
`define OBCL_DBG_EN_BIT 7
`define OBCL_CTRL_MASK_BIT 0
`define OBCL_CAUSE_SUPPLY_LEVEL_RESET_BIT 0
`define OBCL_OPT_RST 8'hFF
`define OBCL_CTRL_RST 8'h00
`define OBCL_CAUSE_RST 8'h01
`define OBCL_LVL_RST 2'h0
`define OBCL_STAB_NS 2000
`define OBCL_CLK_MHZ 250
`define OBCL_STAB_CYC ((`OBCL_STAB_NS * `OBCL_CLK_MHZ + 999) / 1000)
`endif

// File: hdl/obcl_pkg.sv
// types shared by the option byte loader modules
package obcl_pkg;
  typedef enum logic [1:0] {RD_IDLE, RD_REQ, RD_DONE} obcl_rd_state_t;
  typedef enum logic [1:0] {SUP_HOLD, SUP_STAB, SUP_RUN} obcl_sup_state_t;
  typedef logic [7:0] obcl_byte_t;
endpackage

// File: hdl/obcl_nvm_reader.sv
// fetches the four option bytes from the nonvolatile area
`timescale 1ns/100ps
`include "obcl_map.svh"
module obcl_nvm_reader import obcl_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic i_nvm_ack,
  input wire obcl_byte_t i_nvm_rdata,
  output logic o_nvm_req,
  output logic [19:0] o_nvm_addr,
  output logic o_cap_valid,
  output logic [1:0] o_cap_idx,
  output obcl_byte_t o_cap_data,
  output logic o_done
);
  obcl_rd_state_t state_reg, state_next;
  logic [1:0] idx_reg, idx_next;
  logic cap_next;
  obcl_byte_t data_next;
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    cap_next = 1'b0;
    data_next = o_cap_data;
    if (!i_enable) begin
      state_next = RD_IDLE;
      idx_next = 2'h0;
    end else begin
      case (state_reg)
        RD_IDLE: state_next = RD_REQ;
        RD_REQ: begin
          if (i_nvm_ack) begin
            cap_next = 1'b1;
            data_next = i_nvm_rdata;
            if (idx_reg == `OBCL_OPT_LAST) begin // R1
              state_next = RD_DONE;
            end else begin
              idx_next = idx_reg + 2'h1;
            end
          end
        end
        default: state_next = RD_DONE;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= RD_IDLE;
      idx_reg <= 2'h0;
      o_nvm_req <= 1'b0;
      o_nvm_addr <= `OBCL_NVM_BASE;
      o_cap_valid <= 1'b0;
      o_cap_idx <= 2'h0;
      o_cap_data <= 8'h00;
      o_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      o_nvm_req <= state_next == RD_REQ;
      o_nvm_addr <= `OBCL_NVM_BASE + {18'h0, idx_next}; // R1
      o_cap_valid <= cap_next;
      o_cap_idx <= idx_reg;
      o_cap_data <= data_next;
      o_done <= state_next == RD_DONE;
    end
  end
endmodule

// File: hdl/obcl_supply_reset.sv
// supply-level reset: comparator sync, hold, settle wait, release
`timescale 1ns/100ps
`include "obcl_map.svh"
module obcl_supply_reset import obcl_pkg::*; #(
  parameter int STAB_CYCLES = `OBCL_STAB_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_above_rise,
  input wire logic i_below_fall,
  output logic o_int_rst_n,
  output logic o_reset_event
);
  obcl_sup_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  logic rise_meta, rise_s, fall_meta, fall_s;
  logic event_next;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    event_next = 1'b0;
    case (state_reg)
      SUP_HOLD: begin
        cnt_next = 16'h0000;
        if (rise_s && !fall_s) begin // R14
          state_next = SUP_STAB;
        end
      end
      SUP_STAB: begin
        // oscillator settles before the core may run
        if (fall_s) begin // R15
          state_next = SUP_HOLD;
          event_next = 1'b1;
        end else if (cnt_reg == 16'(STAB_CYCLES - 1)) begin // R16
          state_next = SUP_RUN;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      default: begin
        if (fall_s) begin // R15
          state_next = SUP_HOLD;
          event_next = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rise_meta <= 1'b0;
      rise_s <= 1'b0;
      fall_meta <= 1'b1;
      fall_s <= 1'b1;
      state_reg <= SUP_HOLD; // R13
      cnt_reg <= 16'h0000;
      o_int_rst_n <= 1'b0;
      o_reset_event <= 1'b0;
    end else begin
      rise_meta <= i_above_rise;
      rise_s <= rise_meta;
      fall_meta <= i_below_fall;
      fall_s <= fall_meta;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      o_int_rst_n <= state_next == SUP_RUN;
      o_reset_event <= event_next;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  a_hold_keeps_reset: assert property ( // R13
    state_reg == SUP_HOLD |=> !o_int_rst_n)
    else $error("internal reset released straight from hold");
  a_fall_asserts: assert property ( // R15
    fall_s && o_int_rst_n |=> !o_int_rst_n && o_reset_event)
    else $error("supply drop did not reassert reset");
  a_settle_wait: assert property ( // R16
    $rose(o_int_rst_n) |-> $past(cnt_reg) == 16'(STAB_CYCLES - 1))
    else $error("reset released before settle wait ended");
endmodule

// File: verification/obcl_nvm_model.sv
// behavioural model of the nonvolatile option byte area
`timescale 1ns/100ps
module obcl_nvm_model (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_nvm_req,
  input wire logic [19:0] i_nvm_addr,
  input wire logic [31:0] i_image,
  input wire logic [3:0] i_delay,
  output logic o_nvm_ack,
  output logic [7:0] o_nvm_rdata
);
  logic [3:0] wait_reg;
  // data line not valid between answers: it toggles so no stale byte passes
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_reg <= 4'h0;
      o_nvm_ack <= 1'b0;
      o_nvm_rdata <= 8'h00;
    end else begin
      o_nvm_ack <= 1'b0;
      o_nvm_rdata <= ~o_nvm_rdata;
      if (i_nvm_req && !o_nvm_ack) begin
        if (wait_reg >= i_delay) begin
          // four bytes, three user bytes low and the debug byte on top
          o_nvm_ack <= 1'b1;
          o_nvm_rdata <= i_image[8*i_nvm_addr[1:0] +: 8];
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule

// File: verification/option_byte_config_loader_tb.sv
// self-checking bench of the option byte loader
`timescale 1ns/100ps
`include "obcl_map.svh"
module option_byte_config_loader_tb import obcl_pkg::*;;
  localparam int STAB = 4;
  localparam int EXPO [8] = '{6, 7, 8, 9, 11, 13, 14, 16};
  logic clk, arst_n, cyc, stb, we, ack, above, below, nvm_ack, nvm_req;
  logic tick, irq, int_rst_n, cpu_run, loaded, run_en, stby, pin, bad, dbg;
  logic [11:0] adr;
  logic [3:0] sel, delay;
  logic [31:0] wdat, rdat, image;
  obcl_byte_t nvm_rdata;
  logic [19:0] nvm_addr;
  logic [15:0] ovf, ivl;
  logic [1:0] lvl;
  logic [2:0] frq;
  logic [7:0] seen_addr [$];
  int num_errors = 0;
  int samples_checked = 0;

  obcl_top #(.STAB_CYCLES(STAB)) i_dut (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_supply_above_rise(above), .i_supply_below_fall(below),
    .i_nvm_ack(nvm_ack), .i_nvm_rdata(nvm_rdata), .o_nvm_req(nvm_req),
    .o_nvm_addr(nvm_addr), .i_wdt_interval_tick(tick),
    .o_wdt_interval_irq(irq), .o_int_rst_n(int_rst_n), .o_cpu_run(cpu_run),
    .o_cfg_loaded(loaded), .o_wdt_run_enable(run_en),
    .o_wdt_standby_run(stby), .o_wdt_overflow_cnt(ovf),
    .o_wdt_interval_cnt(ivl), .o_reset_pin_select(pin),
    .o_detect_level_sel(lvl), .o_osc_freq_sel(frq), .o_osc_freq_bad(bad),
    .o_debug_enable(dbg));

  obcl_nvm_model i_nvm (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_nvm_req(nvm_req), .i_nvm_addr(nvm_addr), .i_image(image),
    .i_delay(delay), .o_nvm_ack(nvm_ack), .o_nvm_rdata(nvm_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (nvm_ack === 1'b1) seen_addr.push_back(nvm_addr[7:0]);
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // holds the request until the edge that sees ack, takes data there
  task automatic wb(input logic w, input logic [9:0] idx,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    // no limit of its own: the watchdog ends a hung cycle
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    chk(ack, 1'b0);
  endtask

  task automatic pulse_tick(input logic exp);
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    @(posedge clk) chk(irq, exp);
    @(posedge clk) chk(irq, 1'b0);
  endtask

  // drop the supply, reload a fresh image, check every decoded setting
  task automatic reload(input logic [2:0] code);
    logic run;
    logic [31:0] img, q;
    int n;
    run = (code != 3'h2);
    img[7:0] = {3'b111, run, code, run & code[0]};
    img[15:8] = {3'b111, code[2], code[1:0], 2'b11};
    img[23:16] = {5'h1F, code};
    img[31:24] = {code[0], 7'h05};
    below <= 1'b1;
    above <= 1'b0;
    for (n = 0; n < 10 && int_rst_n !== 1'b0; n++) @(posedge clk);
    chk(int_rst_n, 1'b0);
    repeat (3) @(posedge clk);
    chk({cpu_run, loaded}, 2'b00);
    image <= img;
    delay <= {code[0], code[0], 2'h0};
    seen_addr.delete();
    below <= 1'b0;
    above <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 100 && int_rst_n !== 1'b1; n++) @(posedge clk);
    chk(n > STAB, 1'b1);
    chk(int_rst_n, 1'b1);
    for (n = 0; n < 300 && cpu_run !== 1'b1; n++) @(posedge clk);
    chk(cpu_run, 1'b1);
    chk(loaded, 1'b1);
    chk(seen_addr.size(), 4);
    for (n = 0; n < 4 && n < seen_addr.size(); n++)
      chk(seen_addr[n], 8'hC0 + n);
    chk(run_en, img[4]);
    chk(stby, img[0]);
    chk({16'h0, ovf}, (32'h1 << EXPO[code]) - 32'h1);
    chk({16'h0, ivl}, ((32'h1 << EXPO[code]) * 3) >> 2);
    chk(pin, img[12]);
    chk(lvl, img[11:10]);
    chk(frq, code);
    chk(bad, code < 3'h1 || code > 3'h5);
    chk(dbg, img[31]);
    for (n = 0; n < 4; n++) begin
      wb(1'b0, `OBCL_OPT_WDT_IDX + n, 32'h0, q);
      chk(q, {24'h0, img[8*n +: 8]});
    end
    wb(1'b0, `OBCL_STAT_IDX, 32'h0, q);
    chk(q[3:0], {1'b0, bad, 2'b01});
    wb(1'b0, `OBCL_CAUSE_IDX, 32'h0, q);
    chk(q[0], 1'b1);
    wb(1'b0, `OBCL_CAUSE_IDX, 32'h0, q);
    chk(q[0], 1'b0);
  endtask

  // mask, a read-only option byte and an unmapped index
  task automatic bus_and_irq;
    logic [31:0] q;
    wb(1'b0, `OBCL_CTRL_IDX, 32'h0, q);
    chk(q, 32'h0);
    pulse_tick(1'b1);
    wb(1'b1, `OBCL_CTRL_IDX, 32'h1, q);
    pulse_tick(1'b0);
    wb(1'b1, `OBCL_CTRL_IDX, 32'h0, q);
    pulse_tick(1'b1);
    wb(1'b1, `OBCL_OPT_WDT_IDX, 32'h0, q);
    wb(1'b0, `OBCL_OPT_WDT_IDX, 32'h0, q);
    chk(q, {24'h0, image[7:0]});
    chk(run_en, image[4]);
    wb(1'b0, 10'h3FF, 32'h0, q);
    chk(q, 32'h0);
  endtask

  initial begin
    arst_n = 1'b0;
    {cyc, stb, we, tick, above, nvm_ack} = 6'h00;
    below = 1'b1;
    sel = 4'hF;
    adr = 12'h000;
    wdat = 32'h0;
    delay = 4'h0;
    image = 32'hFFFF_FFFF;
    repeat (16) @(posedge clk);
    chk({int_rst_n, cpu_run, frq, lvl}, {2'b00, 3'h1, 2'h0});
    chk(nvm_addr, 20'h000C0);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    chk({int_rst_n, nvm_req, cpu_run}, 3'h0);
    for (int c = 0; c < 8; c++) reload(c[2:0]);
    bus_and_irq();
    give_verdict();
  end

  initial begin
    #(4 * 60000);
    num_errors++;
    give_verdict();
  end
endmodule
